// *** hbd_regs.svh ***
// Constants for the host bus and DMA handshake block.
// Assumes inclusion by bare name from the design file.
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH

// ----------------------------------------
// Port addresses on the two address inputs
// ----------------------------------------
`define HBD_PORT_STATUS  2'h0
`define HBD_PORT_BLOCK   2'h1
`define HBD_PORT_REGPTR  2'h2
`define HBD_PORT_REGDATA 2'h3

// ----------------------------------------
// Widths and clock figures
// ----------------------------------------
`define HBD_DATA_W       16
`define HBD_ACT_W        4
`define HBD_CLK_MAX_MHZ  20
`define HBD_CLK_MHZ      40
`define HBD_SYNC_STAGES  2

`endif

// *** hbd_pkg.sv ***
// Types shared by the host bus and DMA handshake block.
// Assumes no surroundings beyond a SystemVerilog compiler.
package hbd_pkg;

	// ----------------------------------------
	// Kind of queue access taken from the bus
	// ----------------------------------------
	typedef enum logic [2:0] {
		HBD_ACC_NONE,
		HBD_ACC_PORT_RD,
		HBD_ACC_PORT_WR,
		HBD_ACC_FLY_PUSH,
		HBD_ACC_FLY_POP
	} hbd_acc_e;

endpackage

// *** hbd_host_port.sv ***
// Host-side bus control: DMA requests, fly-by steering, buffer enable,
// interrupt and cascade match exchange.
// Assumes synchronous core-side inputs, external pull-ups and an external AND on match.
// How it works
// R1 - Instruction request asserted only when the instruction queue has room.
// R2 - Instruction request is open drain: pulled low when idle, released when requesting.
// R3 - Shared request node rises only after every cascaded device is ready.
// R4 - Block-input transfer requests only when the input queue has room.
// R5 - Block-output transfer requests only when the output queue holds a word.
// R6 - Block request is open drain and wired across devices.
// R7 - Fly-by acknowledge low steers to block queues, ignoring address inputs.
// R8 - Outside master never asserts chip select with fly-by acknowledge.
// R9 - Fly-by write strobe pops output queue; read strobe pushes input queue.
// R10 - No fly-by path exists for the instruction queue.
// R11 - Buffer enable asserted for every chip-selected access to the four ports.
// R12 - Buffer enable also asserted on fly-by acknowledge with any activity bit.
// R13 - System qualifies buffer enable with strobe timing before using it.
// R14 - Interrupt output asserted whenever an interrupt is pending.
// R15 - Everything runs from one core clock, at most 20 MHz; the bench clocks it at 40 MHz.
// R16 - Core clock, pixel clock and host bus are mutually asynchronous.
// R17 - Reset aborts activity at once and forces a defined state.
// R18 - Match output low when no colour match, high on a match.
// R19 - Match outputs are ANDed externally into every match input.
// R20 - Match pair also keeps instruction execution synchronized across devices.
// R21 - Chip select with address picks one of four ports; strobe sets direction.
// R22 - Host strobes and fly-by acknowledge pass two flip-flop stages first.
`include "hbd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module hbd_host_port (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Host strobes, all active low, and the port address
	input  wire logic                       chipSelN,
	input  wire logic                       readN,
	input  wire logic                       writeN,
	input  wire logic [1:0]                 portAddr,
	input  wire logic                       fly_by_acknowledgeN,
	// Queue state from the core
	input  wire logic                       instrQueueRoom,
	input  wire logic                       blockInActive,
	input  wire logic                       blockOutActive,
	input  wire logic                       blockInRoom,
	input  wire logic                       blockOutReady,
	input  wire logic [`HBD_ACT_W-1:0]      activityBits,
	input  wire logic                       irqPending,
	// Cascade match exchange
	input  wire logic                       localMatch,
	input  wire logic                       localSyncReady,
	input  wire logic                       colour_match_in,
	// Open-drain DMA requests (oe low drives the pin low)
	output logic                            instr_queue_request_o,
	output logic                            instr_queue_request_oeN,
	output logic                            block_queue_request_o,
	output logic                            block_queue_request_oeN,
	input  wire logic                       instr_queue_request_i,
	input  wire logic                       block_queue_request_i,
	// Buffer enable and interrupt, active low
	output logic                            ext_buffer_enableN,
	output logic                            irqN,
	// Match out and cascade status
	output logic                            colour_match_out,
	output logic                            cascadeMatch,
	output logic                            cascadeSynced,
	// Queue access strobes toward the core, one-cycle pulses; then the request node levels
	output hbd_pkg::hbd_acc_e               accKind,
	output logic [1:0]                      accPort,
	output logic                            blockPush,
	output logic                            blockPop,
	output logic                            instrReqNode,
	output logic                            blockReqNode
);

	// ----------------------------------------
	// Strobe synchronisers
	// ----------------------------------------
	localparam int NS = 4;
	logic [NS-1:0] syncA_reg;
	logic [NS-1:0] syncB_reg;
	logic [NS-1:0] syncC_reg;
	logic [1:0]    addrA_reg;
	logic [1:0]    addrB_reg;
	logic          csS;
	logic          rdS;
	logic          wrS;
	logic          ackS;
	logic          rdPrev;
	logic          wrPrev;

	// Host bus is asynchronous to clk; first stage read only by second
	always_ff @(posedge clk or posedge rst) begin // R16 R22
		if (rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
			syncC_reg <= '0;
			addrA_reg <= 2'h0;
			addrB_reg <= 2'h0;
		end else begin
			syncA_reg <= {~chipSelN, ~readN, ~writeN, ~fly_by_acknowledgeN};
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			addrA_reg <= portAddr;
			addrB_reg <= addrA_reg;
		end
	end

	assign csS    = syncB_reg[3];
	assign rdS    = syncB_reg[2];
	assign wrS    = syncB_reg[1];
	assign ackS   = syncB_reg[0];
	assign rdPrev = syncC_reg[2];
	assign wrPrev = syncC_reg[1];

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic rdEdge;
	logic wrEdge;
	hbd_pkg::hbd_acc_e accNext;

	assign rdEdge = rdS & ~rdPrev;
	assign wrEdge = wrS & ~wrPrev;

	// Fly-by wins over address decode; instruction queue never sees fly-by
	always_comb begin
		accNext = hbd_pkg::HBD_ACC_NONE;
		if (ackS) begin // R7 R10
			if (wrEdge) begin
				accNext = hbd_pkg::HBD_ACC_FLY_POP; // R9
			end else if (rdEdge) begin
				accNext = hbd_pkg::HBD_ACC_FLY_PUSH; // R9
			end
		end else if (csS) begin // R21
			if (wrEdge) begin
				accNext = hbd_pkg::HBD_ACC_PORT_WR;
			end else if (rdEdge) begin
				accNext = hbd_pkg::HBD_ACC_PORT_RD;
			end
		end
	end

	// Registered access pulses toward the core
	always_ff @(posedge clk or posedge rst) begin // R17
		if (rst) begin
			accKind   <= hbd_pkg::HBD_ACC_NONE;
			accPort   <= 2'h0;
			blockPush <= 1'b0;
			blockPop  <= 1'b0;
		end else begin
			accKind   <= accNext;
			accPort   <= ackS ? `HBD_PORT_BLOCK : addrB_reg; // R7
			blockPush <= (accNext == hbd_pkg::HBD_ACC_FLY_PUSH); // R9
			blockPop  <= (accNext == hbd_pkg::HBD_ACC_FLY_POP); // R9
		end
	end

	// ----------------------------------------
	// Buffer enable
	// ----------------------------------------
	logic anyActivity;
	assign anyActivity = |activityBits;

	// Raw decode only; the board must gate it with strobe timing
	always_ff @(posedge clk or posedge rst) begin // R13
		if (rst) begin
			ext_buffer_enableN <= 1'b1;
		end else begin
			ext_buffer_enableN <= ~((csS & ~ackS) // R11
				| (ackS & anyActivity)); // R12
		end
	end

	// ----------------------------------------
	// DMA requests, open drain
	// ----------------------------------------
	logic instrReq_reg;
	logic blockReq_reg;
	logic blockCause;

	// Input side needs room, output side needs a word waiting
	assign blockCause = (blockInActive & blockInRoom) // R4
		| (blockOutActive & blockOutReady); // R5

	// Requests only when the queue can really take or give a word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instrReq_reg <= 1'b0;
			blockReq_reg <= 1'b0;
		end else begin
			instrReq_reg <= instrQueueRoom; // R1
			blockReq_reg <= blockCause; // R4 R5
		end
	end

	// Pin is driven low while not requesting, released otherwise
	assign instr_queue_request_o   = 1'b0; // R2
	assign instr_queue_request_oeN = instrReq_reg; // R2 R3
	assign block_queue_request_o   = 1'b0; // R6
	assign block_queue_request_oeN = blockReq_reg; // R6
	assign instrReqNode            = instr_queue_request_i; // R3
	assign blockReqNode            = block_queue_request_i;

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqN <= 1'b1;
		end else begin
			irqN <= ~irqPending; // R14
		end
	end

	// ----------------------------------------
	// Cascade match and sync
	// ----------------------------------------
	logic matchIn1_reg;
	logic matchIn2_reg;

	// Match out high on colour match, or while ready in a sync point
	always_ff @(posedge clk or posedge rst) begin // R15
		if (rst) begin
			colour_match_out <= 1'b0;
			matchIn1_reg     <= 1'b0;
			matchIn2_reg     <= 1'b0;
		end else begin
			colour_match_out <= localMatch | localSyncReady; // R18 R20
			matchIn1_reg     <= colour_match_in; // R19
			matchIn2_reg     <= matchIn1_reg;
		end
	end

	assign cascadeMatch  = matchIn2_reg & localMatch;
	assign cascadeSynced = matchIn2_reg & localSyncReady; // R20

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence flyWrite_s;
		ackS && wrEdge;
	endsequence

	sequence popPulse_s;
		blockPop && accKind == hbd_pkg::HBD_ACC_FLY_POP;
	endsequence

	fly_pop_a: assert property (@(posedge clk) disable iff (rst) flyWrite_s |=> popPulse_s) // R9
		else $error("fly-by write did not pop");
	fly_push_a: assert property (@(posedge clk) disable iff (rst) (ackS && rdEdge && !wrEdge) |=> blockPush) // R9
		else $error("fly-by read did not push");
	instr_req_a: assert property (@(posedge clk) disable iff (rst) instr_queue_request_oeN |-> $past(instrQueueRoom)) // R1
		else $error("instruction request without room");
	od_low_a: assert property (@(posedge clk) disable iff (rst) !instr_queue_request_o && !block_queue_request_o) // R2
		else $error("open-drain pin driven high");
	blk_req_a: assert property (@(posedge clk) disable iff (rst) block_queue_request_oeN |-> $past(blockCause)) // R4 R5
		else $error("block request without cause");
	edge_port_a: assert property (@(posedge clk) disable iff (rst) (csS && !ackS) |=> !ext_buffer_enableN) // R11
		else $error("buffer enable missing on port access");
	edge_fly_a: assert property (@(posedge clk) disable iff (rst) (ackS && anyActivity) |=> !ext_buffer_enableN) // R12
		else $error("buffer enable missing on fly-by");
	fly_port_a: assert property (@(posedge clk) disable iff (rst) ackS |=> accPort == `HBD_PORT_BLOCK) // R7
		else $error("fly-by did not steer to block port");
	irq_out_a: assert property (@(posedge clk) disable iff (rst) irqPending |=> !irqN) // R14
		else $error("interrupt not raised");
	match_out_a: assert property (@(posedge clk) disable iff (rst) !(localMatch || localSyncReady) |=> !colour_match_out) // R18
		else $error("match out high without match");
	sync_delay_a: assert property (@(posedge clk) disable iff (rst) $rose(rdS) |-> !$past(readN, 2)) // R22
		else $error("read strobe not delayed two stages");

	// ----------------------------------------
	// Checks on port decode and idle levels
	// ----------------------------------------
	// Port accesses need chip select with no fly-by; write wins a tie
	sequence portRead_s;
		csS && !ackS && rdEdge && !wrEdge;
	endsequence

	sequence portWrite_s;
		csS && !ackS && wrEdge;
	endsequence

	port_rd_a: assert property (@(posedge clk) disable iff (rst)
		portRead_s |=> accKind == hbd_pkg::HBD_ACC_PORT_RD && accPort == $past(addrB_reg)) // R21
		else $error("port read not decoded");
	port_wr_a: assert property (@(posedge clk) disable iff (rst)
		portWrite_s |=> accKind == hbd_pkg::HBD_ACC_PORT_WR && accPort == $past(addrB_reg)) // R21
		else $error("port write not decoded");
	// Fly-by must never reach the instruction side through a port access
	fly_no_instr_a: assert property (@(posedge clk) disable iff (rst) // R10
		ackS |=> accKind != hbd_pkg::HBD_ACC_PORT_RD && accKind != hbd_pkg::HBD_ACC_PORT_WR)
		else $error("fly-by produced a port access");
	// No strobe edge, no access pulse
	quiet_pulse_a: assert property (@(posedge clk) disable iff (rst) // R9
		!(rdEdge || wrEdge) |=> accKind == hbd_pkg::HBD_ACC_NONE && !blockPush && !blockPop)
		else $error("access pulse without strobe");
	// A stray enable would fight the host on the data bus
	buf_idle_a: assert property (@(posedge clk) disable iff (rst) // R11
		!((csS && !ackS) || (ackS && anyActivity)) |=> ext_buffer_enableN)
		else $error("buffer enable without access");
	// Requests must drop once the queue can no longer serve
	instr_drop_a: assert property (@(posedge clk) disable iff (rst) !instrQueueRoom |=> !instr_queue_request_oeN) // R1
		else $error("instruction request held without room");
	blk_drop_a: assert property (@(posedge clk) disable iff (rst) !blockCause |=> !block_queue_request_oeN) // R6
		else $error("block request not pulled low");
	irq_clear_a: assert property (@(posedge clk) disable iff (rst) !irqPending |=> irqN) // R14
		else $error("interrupt held without cause");
	match_hi_a: assert property (@(posedge clk) disable iff (rst) localMatch |=> colour_match_out) // R18
		else $error("match out low on a match");

endmodule

`default_nettype wire

// *** hbd_bus_model.sv ***
// Far side of the host port: pull-ups, cascade peers, match AND, buffer gate.
// Assumes the peer levels come from the bench.
`timescale 1ns/1ps
`default_nettype none

module hbd_bus_model (
	// Open-drain pins of this device
	input  wire logic instrOeN,
	input  wire logic blockOeN,
	input  wire logic instrPin,
	input  wire logic blockPin,
	// Cascade peers, high when ready or matching
	input  wire logic peerInstrRdy,
	input  wire logic peerBlockRdy,
	input  wire logic matchOut,
	input  wire logic peerMatch,
	// Buffer gating
	input  wire logic bufEnN,
	input  wire logic strobeN,
	// Resolved nodes
	output logic      instrNode,
	output logic      blockNode,
	output logic      matchIn,
	output logic      bufOn
);
	// Pull-up wins only when nobody pulls low
	assign instrNode = (instrOeN | instrPin) & peerInstrRdy;
	assign blockNode = (blockOeN | blockPin) & peerBlockRdy;
	// External AND feeds every match input
	assign matchIn = matchOut & peerMatch;
	// Enable alone would crash the bus, so gate with a strobe
	assign bufOn = !bufEnN & !strobeN;
endmodule

`default_nettype wire

// *** hbd_host_port_tb_top.sv ***
// Bench for the host port: requests, port and fly-by accesses, reset.
// Assumes the design and bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "hbd_regs.svh"

module hbd_host_port_tb_top;
	logic clk = 0, rst = 1, csN = 1, rdN = 1, wrN = 1, ackN = 1;
	logic [1:0] addr = 0, aPort;
	logic iRoom = 0, biAct = 0, boAct = 0, biRoom = 0, boRdy = 0, irqP = 0, lMatch = 0, lSync = 0;
	logic peerI = 1, peerB = 1, peerM = 1;
	logic [3:0] act = 0;
	logic iOe, bOe, iO, bO, iNode, bNode, mIn, ebN, irqN, mOut, cMatch, push, pop, iNd, bNd, cSync, bOn;
	hbd_pkg::hbd_acc_e kind;
	int err_total = 0, n_tests = 0;
	logic [4:0] expQ[$];

	always #12.5 clk = ~clk;

	hbd_host_port hbd_host_port_inst (.clk(clk), .rst(rst), .chipSelN(csN), .readN(rdN), .writeN(wrN),
		.portAddr(addr), .fly_by_acknowledgeN(ackN), .instrQueueRoom(iRoom), .blockInActive(biAct),
		.blockOutActive(boAct), .blockInRoom(biRoom), .blockOutReady(boRdy), .activityBits(act),
		.irqPending(irqP), .localMatch(lMatch), .localSyncReady(lSync), .colour_match_in(mIn),
		.instr_queue_request_o(iO), .instr_queue_request_oeN(iOe), .block_queue_request_o(bO),
		.block_queue_request_oeN(bOe), .instr_queue_request_i(iNode), .block_queue_request_i(bNode),
		.ext_buffer_enableN(ebN), .irqN(irqN), .colour_match_out(mOut), .cascadeMatch(cMatch),
		.cascadeSynced(cSync), .accKind(kind), .accPort(aPort), .blockPush(push), .blockPop(pop),
		.instrReqNode(iNd), .blockReqNode(bNd));

	hbd_bus_model hbd_bus_model_inst (.instrOeN(iOe), .blockOeN(bOe), .instrPin(iO), .blockPin(bO),
		.peerInstrRdy(peerI), .peerBlockRdy(peerB), .matchOut(mOut), .peerMatch(peerM), .bufEnN(ebN),
		.strobeN(rdN & wrN), .instrNode(iNode), .blockNode(bNode), .matchIn(mIn), .bufOn(bOn));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("mismatches %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Random queue levels, checked one edge later, cascade status three edges later
	task automatic req;
		logic [10:0] r;
		r = 11'($urandom);
		r[8] = r[8] & !r[9];
		{iRoom, biAct, boAct, biRoom, boRdy, irqP, lMatch, lSync, peerI, peerB, peerM} = r;
		@(negedge clk);
		chk(iOe, iRoom);
		chk({iO, bO}, 0);
		chk(bOe, (biAct & biRoom) | (boAct & boRdy));
		chk({iNd, bNd}, {iRoom & peerI, ((biAct & biRoom) | (boAct & boRdy)) & peerB});
		chk(irqN, !irqP);
		chk(mOut, lMatch | lSync);
		repeat (2) @(negedge clk);
		chk(cMatch, lMatch & peerM);
		chk(cSync, lSync & peerM);
	endtask

	// One strobe; chip select and fly-by are never low together
	task automatic acc(input logic fly, input logic rd, input logic [1:0] a, input logic [2:0] k, input logic en);
		csN = fly;
		ackN = !fly;
		rdN = !rd;
		wrN = rd;
		addr = a;
		expQ.push_back({k, fly ? `HBD_PORT_BLOCK : a});
		repeat (4) @(negedge clk);
		chk(ebN, !en);
		chk(bOn, en);
		{csN, ackN, rdN, wrN} = 4'hf;
		repeat (4) @(negedge clk);
	endtask

	// Scoreboard: each access pulse takes the oldest note
	always @(negedge clk) begin
		if (!rst && kind !== hbd_pkg::HBD_ACC_NONE) begin
			logic [4:0] e;
			e = (expQ.size() > 0) ? expQ.pop_front() : 5'h1f;
			chk(kind, e[4:2]);
			chk(aPort, e[1:0]);
			chk({pop, push}, {e[4:2] == hbd_pkg::HBD_ACC_FLY_POP, e[4:2] == hbd_pkg::HBD_ACC_FLY_PUSH});
		end
	end

	initial begin
		#75000;
		err_total++;
		wrap_up;
	end

	initial begin
		void'($urandom(8990));
		repeat (5) @(negedge clk);
		rst = 0;
		chk({ebN, irqN, iOe}, 3'h6);
		repeat (20) req;
		for (int i = 0; i < 4; i++) begin
			acc(0, 1, i[1:0], hbd_pkg::HBD_ACC_PORT_RD, 1);
			acc(0, 0, i[1:0], hbd_pkg::HBD_ACC_PORT_WR, 1);
		end
		act = 4'h1 << ($urandom % 4);
		acc(1, 0, 2'($urandom), hbd_pkg::HBD_ACC_FLY_POP, 1);
		acc(1, 1, 2'($urandom), hbd_pkg::HBD_ACC_FLY_PUSH, 1);
		act = 0;
		acc(1, 0, 2'($urandom), hbd_pkg::HBD_ACC_FLY_POP, 0);
		// Reset lands in mid-access; nothing must come out
		csN = 0;
		rdN = 0;
		@(negedge clk);
		rst = 1;
		#1;
		chk({ebN, kind, iOe, mOut}, 6'h20);
		{csN, rdN} = 2'h3;
		repeat (5) @(negedge clk);
		rst = 0;
		repeat (4) @(negedge clk);
		chk(8'(expQ.size()), 0);
		wrap_up;
	end
endmodule

`default_nettype wire
